// >>> design/idts_drive_timing_select.sv
// drive timing select: per-drive timing registers and access timing resolution
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "idts_defines.svh"

module idts_drive_timing_select (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  input  wire idts_pkg::idts_acc_s acc,
  output idts_pkg::idts_res_s    res,
  output logic [3:0]             udma_en
);
  import idts_pkg::*;

  idts_state_s st_reg;
  idts_state_s st_next;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // sample point code to clocks; the reserved code yields zero and a flag
  function automatic logic [2:0] isp_clks(input logic [1:0] code);
    logic [2:0] c;
    c = 3'd0;
    case (code)
      2'b00:   c = `IDTS_ISP_CLK_00;
      2'b01:   c = `IDTS_ISP_CLK_01;
      2'b10:   c = `IDTS_ISP_CLK_10;
      default: c = 3'd0;
    endcase
    return c;
  endfunction

  // recovery code to clocks, every code is legal
  function automatic logic [2:0] rct_clks(input logic [1:0] code);
    logic [2:0] c;
    c = 3'd0;
    case (code)
      2'b00:   c = `IDTS_RCT_CLK_00;
      2'b01:   c = `IDTS_RCT_CLK_01;
      2'b10:   c = `IDTS_RCT_CLK_10;
      default: c = `IDTS_RCT_CLK_11;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // access resolution
  // ----------------------------------------------------------------------

  // resolve the timing of one access from the copy of its own cable
  function automatic idts_res_s resolve(input logic [15:0] tim,
                                        input logic [7:0]  slv,
                                        input logic [3:0]  sdma,
                                        input idts_acc_s   a);
    idts_res_s  r;
    logic       bank;
    logic       dte;
    logic       sep;
    logic [1:0] isp;
    logic [1:0] rct;
    r    = '0;
    bank = a.drive ? tim[`IDTS_B_D1_BANK] : tim[`IDTS_B_D0_BANK];
    dte  = a.drive ? tim[`IDTS_B_D1_DTE] : tim[`IDTS_B_D0_DTE];
    // slave fields count only for drive 1 with the split bit set
    sep  = a.drive & tim[`IDTS_B_SEP_SEL];
    if (sep)
    begin
      isp = a.chan ? slv[`IDTS_F_SEC_ISP +: 2] : slv[`IDTS_F_PRI_ISP +: 2];
      rct = a.chan ? slv[`IDTS_F_SEC_RCT +: 2] : slv[`IDTS_F_PRI_RCT +: 2];
    end
    else
    begin
      isp = tim[`IDTS_F_ISP_LO +: 2];
      rct = tim[`IDTS_F_RCT_LO +: 2];
    end
    r.valid = a.valid;
    // dma-only mode leaves pio on compatible timing
    r.fast  = bank & (~dte | a.dma);
    if (r.fast)
    begin
      r.sep_timing    = sep;
      r.sample_clks   = isp_clks(isp);
      r.recovery_clks = rct_clks(rct);
      r.sample_rsvd   = (isp == 2'b11);
    end
    else
    begin
      r.sep_timing    = 1'b0;
      r.sample_clks   = `IDTS_COMPAT_ISP;
      r.recovery_clks = `IDTS_COMPAT_RCT;
      r.sample_rsvd   = 1'b0;
    end
    r.ready_sample_en  = a.drive ? tim[`IDTS_B_D1_RDY] : tim[`IDTS_B_D0_RDY];
    r.prefetch_post_en = a.drive ? tim[`IDTS_B_D1_PPE] : tim[`IDTS_B_D0_PPE];
    r.udma_en          = sdma[{a.chan, a.drive}];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------

  // register writes, read data for the next cycle, and the timing answer
  always_comb
  begin
    st_next       = st_reg;
    st_next.rdata = 16'h0000; // read data stand only in the cycle after a read
    if (reg_wr)
    begin
      case (reg_addr)
        `IDTS_OFF_PRI_TIM:  st_next.pri_tim  = reg_wdata & `IDTS_TIM_MASK;
        `IDTS_OFF_SEC_TIM:  st_next.sec_tim  = reg_wdata & `IDTS_TIM_MASK;
        `IDTS_OFF_SLV_TIM:  st_next.slv_tim  = reg_wdata[7:0];
        `IDTS_OFF_SDMA_CTL: st_next.sdma_ctl = reg_wdata[7:0] & `IDTS_SDMA_MASK;
        default:            st_next.sdma_ctl = st_reg.sdma_ctl;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `IDTS_OFF_PRI_TIM:  st_next.rdata = st_reg.pri_tim;
        `IDTS_OFF_SEC_TIM:  st_next.rdata = st_reg.sec_tim;
        `IDTS_OFF_SLV_TIM:  st_next.rdata = {8'h00, st_reg.slv_tim};
        `IDTS_OFF_SDMA_CTL: st_next.rdata = {8'h00, st_reg.sdma_ctl};
        default:            st_next.rdata = 16'h0000; // unmapped reads zero
      endcase
    end
    // each cable is timed only from its own copy
    st_next.res = resolve(acc.chan ? st_reg.sec_tim : st_reg.pri_tim,
                          st_reg.slv_tim, st_reg.sdma_ctl[3:0], acc);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------

  // synchronous reset puts every register at zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_reg          <= '0;
      st_reg.pri_tim  <= `IDTS_RST_TIM;
      st_reg.sec_tim  <= `IDTS_RST_TIM;
      st_reg.slv_tim  <= `IDTS_RST_SLV;
      st_reg.sdma_ctl <= `IDTS_RST_SDMA;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = st_reg.rdata;
  assign res       = st_reg.res;
  assign udma_en   = st_reg.sdma_ctl[3:0];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  answer_next_cycle_a: assert property (acc.valid |=> res.valid)
    else $error("timing answer missing one cycle after access");

  ready_enable_d0_a: assert property (acc.valid && !acc.drive && !acc.chan && !reg_wr
                                      |=> res.ready_sample_en == st_reg.pri_tim[`IDTS_B_D0_RDY])
    else $error("drive 0 ready sampling does not follow its enable");

  compat_when_bank_off_a: assert property (acc.valid && !acc.drive && !acc.chan
                                           && !st_reg.pri_tim[`IDTS_B_D0_BANK] && !reg_wr
                                           |=> !res.fast && res.sample_clks == `IDTS_COMPAT_ISP)
    else $error("bank bit clear did not give compatible timing");

  pio_compat_dte_a: assert property (acc.valid && !acc.dma && !acc.drive && !acc.chan
                                     && st_reg.pri_tim[`IDTS_B_D0_DTE] && !reg_wr |=> !res.fast)
    else $error("pio access took fast timing in dma-only mode");

  slave_sec_sample_a: assert property (acc.valid && acc.chan && acc.drive && !reg_wr
                                       && st_reg.sec_tim[`IDTS_B_D1_BANK] && !st_reg.sec_tim[`IDTS_B_D1_DTE]
                                       && st_reg.sec_tim[`IDTS_B_SEP_SEL] && st_reg.slv_tim[7:6] == 2'b00
                                       |=> res.sep_timing && res.sample_clks == 3'd5)
    else $error("secondary drive 1 sample point not taken from slave field");

  drive0_no_slave_a: assert property (acc.valid && !acc.drive |=> !res.sep_timing)
    else $error("slave timing applied to drive 0");

  recovery_fast_a: assert property (acc.valid && !acc.chan && !acc.drive && !reg_wr
                                    && st_reg.pri_tim[`IDTS_B_D0_BANK] && !st_reg.pri_tim[`IDTS_B_D0_DTE]
                                    && st_reg.pri_tim[9:8] == 2'b11 |=> res.recovery_clks == 3'd1)
    else $error("channel recovery code 11 not one clock");

  udma_write_a: assert property (reg_wr && reg_addr == `IDTS_OFF_SDMA_CTL
                                 |=> udma_en == $past(reg_wdata[3:0]))
    else $error("synchronous dma enables not updated by write");

  prefetch_d1_a: assert property (acc.valid && acc.drive && acc.chan && !reg_wr
                                  |=> res.prefetch_post_en == st_reg.sec_tim[`IDTS_B_D1_PPE])
    else $error("drive 1 prefetch enable mismatch");

  read_one_cycle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data present without a read");

  // drive 1 on the primary cable samples ready only under its own enable
  ready_enable_d1_a: assert property (acc.valid && acc.drive && !acc.chan && !reg_wr
                                      |=> res.ready_sample_en == st_reg.pri_tim[`IDTS_B_D1_RDY])
    else $error("primary drive 1 ready sampling does not follow its enable");

  // drive 0 on the secondary cable samples ready only under its own enable
  ready_enable_s0_a: assert property (acc.valid && !acc.drive && acc.chan && !reg_wr
                                      |=> res.ready_sample_en == st_reg.sec_tim[`IDTS_B_D0_RDY])
    else $error("secondary drive 0 ready sampling does not follow its enable");

  // an idle cycle never produces an answer
  valid_follows_a: assert property (!acc.valid |=> !res.valid)
    else $error("timing answer without an access");

  // drive 1 bank off on the secondary cable falls back to compatible timing
  compat_d1_off_a: assert property (acc.valid && acc.drive && acc.chan && !st_reg.sec_tim[`IDTS_B_D1_BANK]
                                    |=> !res.fast && res.recovery_clks == `IDTS_COMPAT_RCT)
    else $error("drive 1 bank bit clear did not give compatible timing");

  // a slow answer always carries the compatible sample point and no split
  compat_markers_a: assert property (res.valid && !res.fast
                                     |-> res.sample_clks == `IDTS_COMPAT_ISP && !res.sep_timing)
    else $error("compatible answer carries fast timing values");

  // drive 1 without the split uses the channel sample field
  chan_fields_d1_a: assert property (acc.valid && acc.drive && !acc.chan && !st_reg.pri_tim[`IDTS_B_SEP_SEL]
                                     && st_reg.pri_tim[`IDTS_B_D1_BANK] && !st_reg.pri_tim[`IDTS_B_D1_DTE]
                                     && st_reg.pri_tim[13:12] == 2'b01 |=> !res.sep_timing && res.sample_clks == 3'd4)
    else $error("drive 1 without split did not use channel sample field");

  // drive 0 always uses the channel field, even with the split set
  drive0_chan_a: assert property (acc.valid && !acc.drive && acc.chan && st_reg.sec_tim[`IDTS_B_D0_BANK]
                                  && (!st_reg.sec_tim[`IDTS_B_D0_DTE] || acc.dma)
                                  && st_reg.sec_tim[13:12] == 2'b10 |=> res.sample_clks == 3'd3)
    else $error("drive 0 did not use channel sample field");

  // the dma-only bit still gives dma transfers the fast timing
  dma_fast_dte_a: assert property (acc.valid && acc.dma && !acc.drive && acc.chan
                                   && st_reg.sec_tim[`IDTS_B_D0_BANK] && st_reg.sec_tim[`IDTS_B_D0_DTE] |=> res.fast)
    else $error("dma transfer lost fast timing in dma-only mode");

  // drive 0 prefetch and posting follow its own bit
  prefetch_d0_a: assert property (acc.valid && !acc.drive && !acc.chan && !reg_wr
                                  |=> res.prefetch_post_en == st_reg.pri_tim[`IDTS_B_D0_PPE])
    else $error("drive 0 prefetch enable mismatch");

  // secondary drive 1 sample point from the slave field, code 10
  slave_sec_three_a: assert property (acc.valid && acc.chan && acc.drive && st_reg.sec_tim[`IDTS_B_D1_BANK]
                                      && (!st_reg.sec_tim[`IDTS_B_D1_DTE] || acc.dma) && st_reg.sec_tim[`IDTS_B_SEP_SEL]
                                      && st_reg.slv_tim[7:6] == 2'b10 |=> res.sample_clks == 3'd3)
    else $error("secondary drive 1 sample code 10 not three clocks");

  // secondary drive 1 recovery from the slave field, code 01
  slave_sec_rec_a: assert property (acc.valid && acc.chan && acc.drive && st_reg.sec_tim[`IDTS_B_D1_BANK]
                                    && (!st_reg.sec_tim[`IDTS_B_D1_DTE] || acc.dma) && st_reg.sec_tim[`IDTS_B_SEP_SEL]
                                    && st_reg.slv_tim[5:4] == 2'b01 |=> res.recovery_clks == 3'd3)
    else $error("secondary drive 1 recovery code 01 not three clocks");

  // primary drive 1 sample point from the slave field, code 01
  slave_pri_sample_a: assert property (acc.valid && !acc.chan && acc.drive && st_reg.pri_tim[`IDTS_B_D1_BANK]
                                       && (!st_reg.pri_tim[`IDTS_B_D1_DTE] || acc.dma) && st_reg.pri_tim[`IDTS_B_SEP_SEL]
                                       && st_reg.slv_tim[3:2] == 2'b01 |=> res.sep_timing && res.sample_clks == 3'd4)
    else $error("primary drive 1 sample code 01 not four clocks");

  // primary drive 1 recovery from the slave field, code 00
  slave_pri_rec_a: assert property (acc.valid && !acc.chan && acc.drive && st_reg.pri_tim[`IDTS_B_D1_BANK]
                                    && (!st_reg.pri_tim[`IDTS_B_D1_DTE] || acc.dma) && st_reg.pri_tim[`IDTS_B_SEP_SEL]
                                    && st_reg.slv_tim[1:0] == 2'b00 |=> res.recovery_clks == 3'd4)
    else $error("primary drive 1 recovery code 00 not four clocks");

  // without the split no primary access ever takes the slave fields
  split_off_a: assert property (acc.valid && !acc.chan && !st_reg.pri_tim[`IDTS_B_SEP_SEL]
                                |=> !res.sep_timing)
    else $error("slave timing applied without the split bit");

  // with the split set a fast drive 1 access takes the slave fields
  drive1_split_a: assert property (acc.valid && acc.drive && acc.chan && st_reg.sec_tim[`IDTS_B_D1_BANK]
                                   && (!st_reg.sec_tim[`IDTS_B_D1_DTE] || acc.dma) && st_reg.sec_tim[`IDTS_B_SEP_SEL]
                                   |=> res.sep_timing)
    else $error("split bit did not move drive 1 to slave timing");

  // legal sample codes decode to three to five clocks
  sample_range_a: assert property (res.valid && res.fast && !res.sample_rsvd
                                   |-> res.sample_clks >= 3'd3 && res.sample_clks <= 3'd5)
    else $error("fast sample point outside three to five clocks");

  // every recovery code decodes to one to four clocks
  recovery_range_a: assert property (res.valid && res.fast
                                     |-> res.recovery_clks >= 3'd1 && res.recovery_clks <= 3'd4)
    else $error("fast recovery outside one to four clocks");

  // reserved channel bits always read back as zero
  tim_rsvd_zero_a: assert property (reg_rd && (reg_addr == `IDTS_OFF_PRI_TIM || reg_addr == `IDTS_OFF_SEC_TIM)
                                    |=> reg_rdata[11:10] == 2'b00)
    else $error("reserved channel timing bits read as nonzero");

  // the answer's enable is the stored bit of that cable and drive
  udma_lookup_a: assert property (acc.valid && acc.chan && acc.drive && !reg_wr
                                  |=> res.udma_en == udma_en[3])
    else $error("secondary drive 1 synchronous dma enable mismatch");

  // the enables change only through a write to their register
  udma_hold_a: assert property (!(reg_wr && reg_addr == `IDTS_OFF_SDMA_CTL)
                                |=> $stable(udma_en))
    else $error("synchronous dma enables changed without a write");

  // the upper nibble of the enable register reads as zero
  sdma_upper_zero_a: assert property (reg_rd && reg_addr == `IDTS_OFF_SDMA_CTL
                                      |=> reg_rdata[15:4] == 12'h000)
    else $error("reserved synchronous dma bits read as nonzero");

  // the slave register reads back whole in the low byte
  slave_read_a: assert property (reg_rd && reg_addr == `IDTS_OFF_SLV_TIM
                                 |=> reg_rdata == {8'h00, st_reg.slv_tim})
    else $error("slave timing register read back wrong");

  // the secondary copy alone decides a secondary access
  sec_copy_a: assert property (acc.valid && acc.chan && !acc.drive && st_reg.pri_tim[`IDTS_B_D0_BANK]
                               && !st_reg.sec_tim[`IDTS_B_D0_BANK] |=> !res.fast)
    else $error("primary copy leaked into a secondary access");

endmodule

// >>> shared/idts_defines.svh
// register offsets, field positions, reset values and timing counts of the drive timing select block
`ifndef IDTS_DEFINES_SVH
`define IDTS_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IDTS_OFF_PRI_TIM   8'h40
`define IDTS_OFF_SEC_TIM   8'h42
`define IDTS_OFF_SLV_TIM   8'h44
`define IDTS_OFF_SDMA_CTL  8'h48

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define IDTS_RST_TIM       16'h0000
`define IDTS_RST_SLV       8'h00
`define IDTS_RST_SDMA      8'h00
`define IDTS_TIM_MASK      16'hF3FF
`define IDTS_SDMA_MASK     8'h0F

// ----------------------------------------------------------------------
// channel timing field positions
// ----------------------------------------------------------------------
`define IDTS_B_D0_BANK     0
`define IDTS_B_D0_RDY      1
`define IDTS_B_D0_PPE      2
`define IDTS_B_D0_DTE      3
`define IDTS_B_D1_BANK     4
`define IDTS_B_D1_RDY      5
`define IDTS_B_D1_PPE      6
`define IDTS_B_D1_DTE      7
`define IDTS_B_SEP_SEL     14
`define IDTS_F_RCT_LO      8
`define IDTS_F_ISP_LO      12

// ----------------------------------------------------------------------
// slave timing field positions (low bit of each two-bit field)
// ----------------------------------------------------------------------
`define IDTS_F_PRI_RCT     0
`define IDTS_F_PRI_ISP     2
`define IDTS_F_SEC_RCT     4
`define IDTS_F_SEC_ISP     6

// ----------------------------------------------------------------------
// timing counts in clocks
// ----------------------------------------------------------------------
`define IDTS_ISP_CLK_00    3'd5
`define IDTS_ISP_CLK_01    3'd4
`define IDTS_ISP_CLK_10    3'd3
`define IDTS_RCT_CLK_00    3'd4
`define IDTS_RCT_CLK_01    3'd3
`define IDTS_RCT_CLK_10    3'd2
`define IDTS_RCT_CLK_11    3'd1
`define IDTS_COMPAT_ISP    3'd6
`define IDTS_COMPAT_RCT    3'd7

`endif

// >>> shared/idts_pkg.sv
// types shared by the drive timing select block
package idts_pkg;

  // one data-port or dma access to be timed
  typedef struct packed {
    logic valid;
    logic chan;   // 0 primary cable, 1 secondary cable
    logic drive;  // 0 drive 0, 1 drive 1
    logic dma;    // 1 dma transfer, 0 pio data-port transfer
  } idts_acc_s;

  // resolved timing for that access
  typedef struct packed {
    logic       valid;
    logic       fast;
    logic       sep_timing;
    logic [2:0] sample_clks;
    logic [2:0] recovery_clks;
    logic       sample_rsvd;
    logic       ready_sample_en;
    logic       prefetch_post_en;
    logic       udma_en;
  } idts_res_s;

  // whole state of the block
  typedef struct packed {
    logic [15:0] pri_tim;
    logic [15:0] sec_tim;
    logic [7:0]  slv_tim;
    logic [7:0]  sdma_ctl;
    logic [15:0] rdata;
    idts_res_s   res;
  } idts_state_s;

endpackage

// >>> tb/idts_drive_model.sv
// behavioural model of the cable side that presents data-port and dma accesses
`timescale 1ns/1ns

module idts_drive_model (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           go,
  input  wire logic [2:0]     sel,
  output idts_pkg::idts_acc_s acc
);
  import idts_pkg::*;
  // one access per request, held for a single cycle so each answer pairs with one ask
  always_ff @(posedge core_clk)
    if (rst)
      acc <= '0;
    else
      acc <= go ? {1'b1, sel} : 4'h0;
endmodule

// >>> tb/idts_drive_timing_select_test.sv
// self-checking bench for the drive timing select block
`timescale 1ns/1ns
`include "idts_defines.svh"

module idts_drive_timing_select_test;
  import idts_pkg::*;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        go        = 1'b0;
  logic [2:0]  sel       = 3'h0; // {chan, drive, dma}
  idts_acc_s   acc;
  idts_res_s   res;
  logic [3:0]  udma_en;
  logic [15:0] pri;
  logic [15:0] sec;
  logic [7:0]  slv;
  logic [7:0]  sdma;
  int          n_errors  = 0;
  int          checked   = 0;

  always #25 core_clk = ~core_clk;

  idts_drive_model drv_u (.core_clk(core_clk), .rst(rst), .go(go), .sel(sel), .acc(acc));
  idts_drive_timing_select dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc(acc), .res(res), .udma_en(udma_en));

  // ----------------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands one cycle only, so the idle cycle after it is checked too
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    chk("reg_rdata", reg_rdata, exp);
    @(negedge core_clk);
    chk("reg_rdata idle", reg_rdata, 16'h0000);
  endtask

  // expected answer from the bench's own copy of the registers
  function automatic idts_res_s exp_res(input logic [2:0] s);
    logic [15:0] t;
    logic [3:0]  n;
    logic        f;
    logic        sp;
    logic [1:0]  ic;
    logic [1:0]  rc;
    t  = s[2] ? sec : pri;
    n  = s[1] ? t[7:4] : t[3:0];
    f  = n[0] & (~n[3] | s[0]);
    sp = s[1] & t[14];
    ic = sp ? (s[2] ? slv[7:6] : slv[3:2]) : t[13:12];
    rc = sp ? (s[2] ? slv[5:4] : slv[1:0]) : t[9:8];
    exp_res = {1'b1, f, f & sp, f ? 3'd5 - ic : 3'd6, f ? 3'd4 - rc : 3'd7, 1'b0, n[1], n[2], sdma[s[2:1]]};
  endfunction

  // access goes through the cable model, answer lands two edges later
  task automatic acc_chk(input logic [2:0] s);
    @(posedge core_clk);
    go  <= 1'b1;
    sel <= s;
    @(posedge core_clk);
    go  <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("res", 16'(res), 16'(exp_res(s)));
  endtask

  // program all registers, then try every cable, drive and transfer kind
  task automatic cfg(input logic [15:0] p, input logic [15:0] q, input logic [7:0] v, input logic [7:0] m);
    pri  = p;
    sec  = q;
    slv  = v;
    sdma = m;
    wr(`IDTS_OFF_PRI_TIM, p);
    wr(`IDTS_OFF_SEC_TIM, q);
    wr(`IDTS_OFF_SLV_TIM, {8'h00, v});
    wr(`IDTS_OFF_SDMA_CTL, {8'h00, m});
    for (int i = 0; i < 8; i++)
      acc_chk(3'(i));
    chk("udma_en", {12'h000, udma_en}, {12'h000, m[3:0]});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(`IDTS_OFF_PRI_TIM, `IDTS_RST_TIM);
    rd(`IDTS_OFF_SEC_TIM, `IDTS_RST_TIM);
    rd(`IDTS_OFF_SLV_TIM, {8'h00, `IDTS_RST_SLV});
    rd(`IDTS_OFF_SDMA_CTL, {8'h00, `IDTS_RST_SDMA});
    wr(`IDTS_OFF_PRI_TIM, 16'hFFFF);
    rd(`IDTS_OFF_PRI_TIM, 16'hF3FF);
    wr(`IDTS_OFF_SDMA_CTL, 16'hFFFF);
    rd(`IDTS_OFF_SDMA_CTL, 16'h000F);
    wr(8'h50, 16'hFFFF);
    rd(8'h50, 16'h0000);
    $display("test registers done");
    cfg(16'h0000, 16'h0000, 8'h00, 8'h00);
    $display("test compatible done");
    // sample codes kept to legal values only
    cfg(16'h1077, 16'h62F9, 8'h9B, 8'h0A);
    cfg(16'h4133, 16'h0000, 8'h24, 8'h05);
    $display("test fast timing done");
    end_sim;
  end

  // hang guard: far beyond the roughly 130 cycles the sequence needs
  initial
  begin
    #2000000;
    n_errors++;
    end_sim;
  end
endmodule
